/* src/dram_timing_mode_config.v */
/*
  DRAM timing and mode configuration: holds the timing and controller mode
  registers, decodes them into clock counts for the command sequencer, and
  runs the refresh and row-open limit timers.
  Assumes a 125 MHz DRAM clock, a simple single-cycle register port with
  byte enables, and a sequencer that reports activates and precharges.
*/
// Contract
// - Timing bit 10 picks row-open limit 120/70us.
// - Bits 9:7 give minimum activate-to-precharge clocks.
// - Bits 6:5 pick read latency 2.5/2/3.
// - Bits 3:2 give activate-to-column clocks 4/3/2.
// - Bits 1:0 give precharge-to-activate clocks 4/3/2.
// - Virtual single channel shares one timing set.
// - Refresh field picks 15.6, 7.8, 64us.
// - Refresh code 111 refreshes every 64 clocks.
`timescale 1ns/1ps
`default_nettype none
`include "dram_timing_regs.vh"

module dram_timing_mode_config #(
  parameter RAS_LONG_CLKS = (`RAS_MAX_LONG_NS * 1000) / `CLK_PERIOD_PS,
  parameter RAS_SHORT_CLKS = (`RAS_MAX_SHORT_NS * 1000) / `CLK_PERIOD_PS,
  parameter REF_15US6_CLKS = (`REFRESH_15US6_NS * 1000) / `CLK_PERIOD_PS,
  parameter REF_7US8_CLKS = (`REFRESH_7US8_NS * 1000) / `CLK_PERIOD_PS,
  parameter REF_64US_CLKS = (`REFRESH_64US_NS * 1000) / `CLK_PERIOD_PS
) (
  input wire sys_clk_in,
  input wire reset_n_in,
  input wire reg_write_in,
  input wire reg_read_in,
  input wire [7:0] reg_addr_in,
  input wire [3:0] reg_byte_en_in,
  input wire [31:0] reg_wdata_in,
  output reg [31:0] reg_rdata_out,
  output reg reg_ack_out,
  input wire activate_in,
  input wire precharge_in,
  input wire refresh_done_in,
  output reg [3:0] ras_min_clks_out,
  output reg [2:0] cas_half_clks_out,
  output reg [2:0] rcd_clks_out,
  output reg [2:0] rp_clks_out,
  output reg init_done_flag_out,
  output reg [1:0] channel_count_sel_out,
  output reg refresh_enable_out,
  output reg refresh_req_out,
  output reg row_close_req_out
);

  reg [31:0] dram_timing_params;
  reg [31:0] dram_controller_mode;
  reg row_open;
  reg [14:0] ras_period;
  reg [13:0] ref_period;
  reg ref_valid;
  reg mode_write_seen;
  wire [2:0] refresh_rate_sel;
  wire ref_expire;
  wire ras_expire;
  wire [31:0] wmask;

  ////////////////////////////////////////////////////////////////////////////////
  // Register port

  // Expand byte enables into a bit mask.
  function [31:0] lane_mask;
    input [3:0] be;
    begin
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  assign wmask = lane_mask(reg_byte_en_in);

  // Only documented writable bits change; reserved bits hold zero. Software is
  // expected to keep the channel field at 00, and no other code is decoded.
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dram_timing_params <= `TIMING_PARAMS_RESET;
      dram_controller_mode <= `CONTROLLER_MODE_RESET;
    end else if (reg_write_in) begin
      if (reg_addr_in == `TIMING_PARAMS_OFFSET) begin
        dram_timing_params <= (dram_timing_params & ~(wmask & `TIMING_WRITE_MASK)) |
                              (reg_wdata_in & wmask & `TIMING_WRITE_MASK);
      end
      if (reg_addr_in == `CONTROLLER_MODE_OFFSET) begin
        dram_controller_mode <= (dram_controller_mode & ~(wmask & `MODE_WRITE_MASK)) |
                                (reg_wdata_in & wmask & `MODE_WRITE_MASK) | `MODE_READ_ONLY;
      end
    end
  end

  // Reads answer one cycle later; unmapped offsets read as zero.
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 32'h00000000;
      reg_ack_out <= 1'b0;
    end else begin
      reg_ack_out <= reg_read_in | reg_write_in;
      if (reg_read_in && reg_addr_in == `TIMING_PARAMS_OFFSET) begin
        reg_rdata_out <= dram_timing_params;
      end else if (reg_read_in && reg_addr_in == `CONTROLLER_MODE_OFFSET) begin
        reg_rdata_out <= dram_controller_mode;
      end else begin
        reg_rdata_out <= 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decoded timing for the sequencer

  // Map a 2-bit code 00/01/10 to 4/3/2 clocks; reserved 11 falls back to 4.
  function [2:0] gap_clks;
    input [1:0] code;
    begin
      case (code)
        2'h0: gap_clks = 3'h4;
        2'h1: gap_clks = 3'h3;
        2'h2: gap_clks = 3'h2;
        default: gap_clks = 3'h4;
      endcase
    end
  endfunction

  // One timing set serves every physical channel, so back-to-back cycles to
  // different channels are spaced as if to the same one.
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ras_min_clks_out <= 4'ha;
      cas_half_clks_out <= 3'h5;
      rcd_clks_out <= 3'h4;
      rp_clks_out <= 3'h4;
      init_done_flag_out <= 1'b0;
      channel_count_sel_out <= 2'h0;
      refresh_enable_out <= 1'b0;
    end else begin
      // Reserved codes above 101 clamp to the safest 10 clocks.
      if (dram_timing_params[`RAS_MIN_HI:`RAS_MIN_LO] > 3'h5) begin
        ras_min_clks_out <= 4'ha;
      end else begin
        ras_min_clks_out <= 4'ha - {1'b0, dram_timing_params[`RAS_MIN_HI:`RAS_MIN_LO]};
      end
      // Latency in half clocks so 2.5 is exact; reserved 11 uses 3.
      case (dram_timing_params[`CAS_LAT_HI:`CAS_LAT_LO])
        2'h0: cas_half_clks_out <= 3'h5;
        2'h1: cas_half_clks_out <= 3'h4;
        default: cas_half_clks_out <= 3'h6;
      endcase
      rcd_clks_out <= gap_clks(dram_timing_params[`RCD_HI:`RCD_LO]);
      rp_clks_out <= gap_clks(dram_timing_params[`RP_HI:`RP_LO]);
      init_done_flag_out <= dram_controller_mode[`INIT_DONE_BIT];
      channel_count_sel_out <= dram_controller_mode[`CHANNEL_COUNT_SEL_HI:`CHANNEL_COUNT_SEL_LO];
      refresh_enable_out <= ref_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Refresh timer

  assign refresh_rate_sel = dram_controller_mode[`REFRESH_HI:`REFRESH_LO];

  // Interval in clocks; reserved codes disable refresh rather than guess.
  always @* begin
    ref_valid = 1'b1;
    case (refresh_rate_sel)
      `REFRESH_15US6: ref_period = REF_15US6_CLKS[13:0];
      `REFRESH_7US8: ref_period = REF_7US8_CLKS[13:0];
      `REFRESH_64US: ref_period = REF_64US_CLKS[13:0];
      `REFRESH_FAST: ref_period = `REFRESH_FAST_CLKS;
      default: begin
        ref_period = 14'h0000;
        ref_valid = 1'b0;
      end
    endcase
  end

  // The timer reloads one cycle after a mode write, once the new rate code
  // stands; loading on the write edge itself would take the old period and a
  // zero count would fire a refresh request at once.
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_write_seen <= 1'b0;
    end else begin
      mode_write_seen <= reg_write_in && (reg_addr_in == `CONTROLLER_MODE_OFFSET);
    end
  end

  interval_timer #(.WIDTH(14)) refresh_timer (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .enable_in(ref_valid),
    .load_in(mode_write_seen),
    .period_in(ref_period),
    .expire_out(ref_expire)
  );

  // Request stands until the sequencer, having closed rows, reports the
  // refresh or refresh is disabled; a new expiry in the same cycle wins over the acknowledge.
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      refresh_req_out <= 1'b0;
    end else if (ref_expire) begin
      refresh_req_out <= 1'b1;
    end else if (refresh_done_in || !ref_valid) begin
      refresh_req_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Row-open limit

  // The limit is pulled in by a fixed 16-clock budget so the sequencer has
  // time to issue the precharge before the hard limit passes.
  always @* begin
    if (dram_timing_params[`RAS_MAX_BIT]) begin
      ras_period = RAS_SHORT_CLKS[14:0] - 15'h0010;
    end else begin
      ras_period = RAS_LONG_CLKS[14:0] - 15'h0010;
    end
  end

  // Tracks whether any row is open; precharge closes all for this purpose.
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      row_open <= 1'b0;
    end else if (activate_in) begin
      row_open <= 1'b1;
    end else if (precharge_in) begin
      row_open <= 1'b0;
    end
  end

  interval_timer #(.WIDTH(15)) ras_timer (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .enable_in(row_open),
    .load_in(activate_in),
    .period_in(ras_period),
    .expire_out(ras_expire)
  );

  // Ask the sequencer to precharge before the row-open limit runs out.
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      row_close_req_out <= 1'b0;
    end else if (ras_expire && row_open) begin
      row_close_req_out <= 1'b1;
    end else if (precharge_in || activate_in) begin
      row_close_req_out <= 1'b0;
    end
  end

endmodule // dram_timing_mode_config

`default_nettype wire

/* common/dram_timing_regs.vh */
/*
  Register offsets, field positions, reset values and timing figures for the
  DRAM timing and mode configuration block.
  Assumes the register port addresses bytes and that each register is one 32-bit word.
*/
`ifndef DRAM_TIMING_REGS_VH
`define DRAM_TIMING_REGS_VH

// Register byte offsets.
`define TIMING_PARAMS_OFFSET 8'h60
`define CONTROLLER_MODE_OFFSET 8'h68

// Reset values.
`define TIMING_PARAMS_RESET 32'h00000000
`define CONTROLLER_MODE_RESET 32'h00000001

// Timing register fields.
`define RAS_MAX_BIT 10
`define RAS_MIN_HI 9
`define RAS_MIN_LO 7
`define CAS_LAT_HI 6
`define CAS_LAT_LO 5
`define RCD_HI 3
`define RCD_LO 2
`define RP_HI 1
`define RP_LO 0
`define TIMING_WRITE_MASK 32'h000007ef

// Controller mode register fields.
`define INIT_DONE_BIT 29
`define CHANNEL_COUNT_SEL_HI 22
`define CHANNEL_COUNT_SEL_LO 21
`define REFRESH_HI 10
`define REFRESH_LO 8
`define MODE_WRITE_MASK 32'h20600700
`define MODE_READ_ONLY 32'h00000001

// Refresh rate codes.
`define REFRESH_15US6 3'h1
`define REFRESH_7US8 3'h2
`define REFRESH_64US 3'h3
`define REFRESH_FAST 3'h7

// Times in nanoseconds, the clock period in picoseconds and the fast refresh interval in clocks.
`define CLK_PERIOD_PS 8000
`define RAS_MAX_LONG_NS 120000
`define RAS_MAX_SHORT_NS 70000
`define REFRESH_15US6_NS 15600
`define REFRESH_7US8_NS 7800
`define REFRESH_64US_NS 64000
`define REFRESH_FAST_CLKS 14'h0040

`endif

/* src/interval_timer.v */
/*
  Reloadable down counter that pulses when a programmed interval expires.
  Assumes a single clock; load restarts the count from the given value.
*/
`timescale 1ns/1ps
`default_nettype none

module interval_timer #(
  parameter WIDTH = 16
) (
  input wire sys_clk_in,
  input wire reset_n_in,
  input wire enable_in,
  input wire load_in,
  input wire [WIDTH-1:0] period_in,
  output reg expire_out
);

  reg [WIDTH-1:0] count;

  // Count down while enabled; expiry reloads so the pulses stay periodic.
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count <= {WIDTH{1'b0}};
      expire_out <= 1'b0;
    end else if (load_in || !enable_in) begin
      count <= period_in;
      expire_out <= 1'b0;
    end else if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
      count <= period_in;
      expire_out <= 1'b1;
    end else begin
      count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      expire_out <= 1'b0;
    end
  end

endmodule // interval_timer

`default_nettype wire

/* tb/dram_cfg_checker_props.sv */
/* Port checker for the DRAM timing and mode block.
   Assumes one clock and the block's asynchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module dram_cfg_checker (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic precharge_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic reg_ack_out,
  input wire logic [3:0] ras_min_clks_out,
  input wire logic [2:0] cas_half_clks_out,
  input wire logic [2:0] rcd_clks_out,
  input wire logic refresh_enable_out,
  input wire logic refresh_req_out,
  input wire logic row_close_req_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // A strobe of either kind is a register request.
  sequence s_strobe;
    reg_write_in || reg_read_in;
  endsequence
  // Acks follow strobes and idle read data is zero; decoded ras min, latency and rcd values must never leave the documented sets, even after a reserved code.
  a_ack_follows: assert property (s_strobe |=> reg_ack_out) else $error("ack missing after strobe");
  a_ack_caused: assert property (reg_ack_out |-> $past(reg_write_in || reg_read_in)) else $error("stray ack");
  a_rdata_idle: assert property (!reg_ack_out |-> reg_rdata_out == 32'h0) else $error("read data not idle");
  a_ras_min_range:
    assert property (ras_min_clks_out inside {[4'h5:4'ha]}) else $error("ras min out of set");
  a_cas_codes:
    assert property (cas_half_clks_out inside {3'h4, 3'h5, 3'h6}) else $error("latency out of set");
  a_rcd_range:
    assert property (rcd_clks_out inside {[3'h2:3'h4]}) else $error("rcd out of set");
  a_refresh_gated:
    assert property ($rose(refresh_req_out) |-> $past(refresh_enable_out)) else $error("refresh while off");
  a_row_close_clear:
    assert property (precharge_in |=> !row_close_req_out) else $error("row close not cleared");
endmodule // dram_cfg_checker
////////////////////////////////
bind dram_timing_mode_config dram_cfg_checker chk_u (.*);
`default_nettype wire

/* tb/seq_model.sv */
/* Command sequencer stand-in: opens a row on request, closes it when asked, serves refreshes.
   Assumes the block's request levels and one shared clock. */
`timescale 1ns/1ps
`default_nettype none
module seq_model (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic open_row_in,
  input wire logic slow_in,
  input wire logic refresh_req_in,
  input wire logic row_close_req_in,
  output logic activate_out,
  output logic precharge_out,
  output logic refresh_done_out
);
  logic row_open;
  logic [4:0] wait_cnt;
  // Rows close before a refresh is served; a slow reply waits 20 clocks to stress the hold.
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      {row_open, wait_cnt, activate_out, precharge_out, refresh_done_out} <= '0;
    end else begin
      {activate_out, precharge_out, refresh_done_out} <= 3'h0;
      if (row_open && (row_close_req_in || refresh_req_in)) begin
        precharge_out <= 1'b1;
        row_open <= 1'b0;
      end else if (open_row_in && !row_open) begin
        activate_out <= 1'b1;
        row_open <= 1'b1;
      end else if (refresh_req_in && !refresh_done_out) begin
        wait_cnt <= wait_cnt + 5'h1;
        if (wait_cnt >= (slow_in ? 5'h14 : 5'h1)) begin
          refresh_done_out <= 1'b1;
          wait_cnt <= 5'h0;
        end
      end
    end
  end
endmodule // seq_model
`default_nettype wire

/* tb/tb.sv */
/* Testbench for the DRAM timing block: registers, decoded timing, row limit and refresh timers.
   Assumes the sequencer stand-in answers row-close and refresh requests. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk_in = 0, reset_n_in = 0, reg_write_in = 0, reg_read_in = 0, open_row = 0, slow = 0;
  logic [7:0] reg_addr_in = 8'h0;
  logic [3:0] reg_byte_en_in = 4'h0, ras_min_clks_out;
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, d;
  logic [2:0] cas_half_clks_out, rcd_clks_out, rp_clks_out, cas_e[3] = '{3'h5, 3'h4, 3'h6};
  logic [1:0] channel_count_sel_out, j;
  logic reg_ack_out, activate_in, precharge_in, refresh_done_in, init_done_flag_out;
  logic refresh_enable_out, refresh_req_out, row_close_req_out;
  int err_count = 0, check_count = 0, n, lim[2] = '{84, 64}, per[4] = '{40, 30, 60, 64};
  wire logic [12:0] dec = {ras_min_clks_out, cas_half_clks_out, rcd_clks_out, rp_clks_out};
  // Small counts keep the row and refresh timers short.
  dram_timing_mode_config #(.RAS_LONG_CLKS(100), .RAS_SHORT_CLKS(80), .REF_15US6_CLKS(40),
    .REF_7US8_CLKS(30), .REF_64US_CLKS(60)) dut_u (.*);
  seq_model seq_u (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .open_row_in(open_row), .slow_in(slow),
    .refresh_req_in(refresh_req_out), .row_close_req_in(row_close_req_out), .activate_out(activate_in),
    .precharge_out(precharge_in), .refresh_done_out(refresh_done_in));
  ////////////////////////////////
  // Clock and watchdog.
  initial forever #4 sys_clk_in = ~sys_clk_in;
  initial begin
    #20000;
    err_count++;
    test_done();
  end
  task automatic chk(input logic [35:0] g, e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_win(input int g, lo, hi);
    chk({35'h0, g < lo || g > hi}, 36'h0);
  endtask
  // Writes return three edges later so decoded outputs have settled.
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
    reg_addr_in <= a;
    reg_byte_en_in <= b;
    reg_wdata_in <= v;
    reg_write_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_write_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_read_in <= 1'b0;
    @(negedge sys_clk_in);
    chk({3'h0, reg_ack_out, reg_rdata_out}, {4'h1, e});
    @(posedge sys_clk_in);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return refresh_req_out;
      1: return !refresh_req_out;
      2: return row_close_req_out;
      default: return !row_close_req_out;
    endcase
  endfunction
  task automatic wait_for(input int s, output int c);
    c = 0;
    do begin
      @(negedge sys_clk_in);
      c++;
    end while (pick(s) !== 1'b1 && c < 400);
    @(posedge sys_clk_in);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////
  // Main sequence.
  initial begin
    repeat (3) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    @(posedge sys_clk_in);
    rd(8'h60, 32'h0);
    rd(8'h68, 32'h1);
    rd(8'h64, 32'h0);
    chk({23'h0, dec}, {23'h0, 4'ha, 3'h5, 3'h4, 3'h4});
    for (int i = 0; i < 6; i++) begin
      j = 2'(i % 3);
      d = {21'h0, i[0], i[2:0], j, 1'b1, j, j};
      wr(8'h60, 4'hf, d);
      rd(8'h60, d & 32'h7ef);
      chk({23'h0, dec}, {23'h0, 4'(10 - i), cas_e[j], 3'(4 - j), 3'(4 - j)});
    end
    wr(8'h60, 4'h2, 32'h0);
    rd(8'h60, 32'h0ca);
    wr(8'h68, 4'hf, 32'hdf9ff8fe);
    rd(8'h68, 32'h1);
    wr(8'h68, 4'hf, 32'h20000000);
    rd(8'h68, 32'h20000001);
    chk({33'h0, init_done_flag_out, channel_count_sel_out}, 36'h4);
    for (int k = 0; k < 2; k++) begin
      wr(8'h60, 4'h2, {21'h0, k[0], 10'h0});
      open_row <= 1'b1;
      // Three cycles beyond the limit pass between raising open_row and the request showing:
      // the stand-in's activate, the timer load and the registered request.
      wait_for(2, n);
      open_row <= 1'b0;
      chk_win(n, lim[k] + 2, lim[k] + 6);
      wait_for(3, n);
      chk_win(n, 1, 3);
    end
    for (int k = 0; k < 4; k++) begin
      slow <= k[0];
      wr(8'h68, 4'h2, 32'h0);
      chk({35'h0, refresh_enable_out}, 36'h0);
      wr(8'h68, 4'h2, {21'h0, (k == 3) ? 3'h7 : 3'(k + 1), 8'h0});
      wait_for(0, n);
      chk_win(n, per[k] - 3, per[k] + 4);
      wait_for(1, n);
      chk_win(n, 1, k[0] ? 30 : 6);
    end
    test_done();
  end
endmodule // tb
`default_nettype wire
